// File: dfmap_asserts.sv
// Checker of the data map, on the top module's ports.
// Assumes clk_sys only and active-low rst_n.
module dfmap_asserts (
  // Clock and reset
  input logic        clk_sys,
  input logic        rst_n,
  // Query and answer
  input logic        req_valid,
  input logic        req_ready,
  input logic        req_coil,
  input logic        req_write,
  input logic [15:0] req_addr,
  input logic [15:0] req_wdata,
  input logic        rsp_valid,
  input logic        rsp_exc,
  input logic [15:0] rsp_data,
  // Drive side
  input logic [15:0] process_command_word,
  input logic [15:0] drv_last_error,
  // Parameter store
  input logic        par_valid,
  input logic        par_write,
  input logic [12:0] par_num,
  input logic [3:0]  par_word,
  input logic        par_ack,
  input logic        par_err,
  input logic [15:0] par_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Helpers
  logic        take;
  logic        par_hit;
  logic [16:0] reg_no;
  assign take    = req_valid && req_ready;
  assign par_hit = !req_coil && req_addr >= 16'h0009 && req_addr <= 16'hC34E;
  assign reg_no  = {1'h0, req_addr} + 17'h00001;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  sequence par_take_s;
    take && par_hit;
  endsequence
  sequence par_done_s;
    par_valid && par_ack;
  endsequence

  quick_answer_a: assert property (take && !par_hit |=> rsp_valid)
    else $error("late answer");
  par_issue_a: assert property (par_take_s |=> par_valid && !req_ready &&
    par_num == 13'($past(reg_no) / 17'd10) && par_word == 4'($past(reg_no) % 17'd10))
    else $error("bad par fields");
  par_hold_a: assert property (par_valid && !par_ack |=> par_valid && $stable(par_num))
    else $error("par dropped");
  par_reply_a: assert property (par_done_s |=> rsp_valid && !par_valid && req_ready
    && rsp_exc == $past(par_err)) else $error("bad par answer");
  par_data_a: assert property (par_done_s and !par_err && !par_write |=>
    rsp_data == $past(par_rdata)) else $error("bad par data");
  cmd_write_a: assert property (take && req_write && !req_coil && req_addr == 16'hC34F
    |=> process_command_word == $past(req_wdata) && !rsp_exc)
    else $error("cmd write lost");
  coil_write_a: assert property (take && req_write && req_coil && req_addr < 16'h0010
    |=> process_command_word[$past(req_addr[3:0])] == $past(req_wdata[0]))
    else $error("coil write lost");
  ro_coil_a: assert property (take && req_write && req_coil && req_addr >= 16'h0020
    && req_addr <= 16'h003F |=> rsp_exc) else $error("status write taken");
  rsv_coil_a: assert property (take && req_coil && req_addr > 16'h0040 |=>
    rsp_valid && rsp_exc && rsp_data == 16'h0000) else $error("bad coil taken");
  rsv_reg_a: assert property (take && !req_coil && (req_addr < 16'h0006 ||
    req_addr == 16'h0007) |=> rsp_exc) else $error("bad reg taken");
  err_read_a: assert property (take && !req_write && !req_coil && req_addr == 16'h0006
    |=> rsp_data == $past(drv_last_error) && !rsp_exc) else $error("bad error read");
endmodule : dfmap_asserts

bind dfmap_top dfmap_asserts u_chk (.clk_sys, .rst_n, .req_valid, .req_ready, .req_coil,
  .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_exc, .rsp_data, .process_command_word,
  .drv_last_error, .par_valid, .par_write, .par_num, .par_word, .par_ack, .par_err, .par_rdata);

// File: dfmap_dec_if.sv
// Carrier between the data map and its address decoder.
// Assumes both ends sit in the same clock domain; it holds no state.
interface dfmap_dec_if;
  logic                   is_coil;
  logic [15:0]            addr;
  dfmap_pkg::dfmap_region_t region;
  logic [3:0]             bit_sel;
  logic [12:0]            par_num;
  logic [3:0]             par_word;

  modport map (output is_coil, output addr, input region, input bit_sel,
               input par_num, input par_word);
  modport dec (input is_coil, input addr, output region, output bit_sel,
               output par_num, output par_word);
endinterface : dfmap_dec_if

// File: dfmap_decode.sv
// Address decoder for the fieldbus data map.
// Assumes addresses arrive zero-based, as carried in the message.
module dfmap_decode (
  // Decode request and result
  dfmap_dec_if.dec d
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [16:0] reg_num;
  logic [16:0] quo;
  logic [16:0] rem;

  // Register number is address plus one
  assign reg_num = {1'b0, d.addr} + 17'h00001;
  assign quo     = reg_num / dfmap_pkg::REG_PARAM_STEP;
  assign rem     = reg_num % dfmap_pkg::REG_PARAM_STEP;

  // Region select; anything unlisted is reserved
  always_comb begin
    d.region   = dfmap_pkg::DFMAP_NONE;
    d.bit_sel  = d.addr[3:0];
    d.par_num  = quo[12:0];
    d.par_word = rem[3:0];
    if (d.is_coil) begin
      if (d.addr < dfmap_pkg::COIL_REF_BASE) begin
        d.region = dfmap_pkg::DFMAP_C_CMD;
      end else if (d.addr < dfmap_pkg::COIL_STAT_BASE) begin
        d.region = dfmap_pkg::DFMAP_C_REF;
      end else if (d.addr < dfmap_pkg::COIL_ACT_BASE) begin
        d.region = dfmap_pkg::DFMAP_C_STW;
      end else if (d.addr < dfmap_pkg::COIL_STORE_ADDR) begin
        d.region = dfmap_pkg::DFMAP_C_ACT;
      end else if (d.addr == dfmap_pkg::COIL_STORE_ADDR) begin
        d.region = dfmap_pkg::DFMAP_C_STO;
      end
    end else begin
      // The function code already says holding register
      if (reg_num == dfmap_pkg::REG_LAST_ERROR) begin
        d.region = dfmap_pkg::DFMAP_H_ERR;
      end else if (reg_num == dfmap_pkg::REG_ARRAY_INDEX) begin
        d.region = dfmap_pkg::DFMAP_H_IDX;
      end else if (reg_num >= dfmap_pkg::REG_PARAM_FIRST &&
                   reg_num <= dfmap_pkg::REG_PARAM_LAST) begin
        d.region = dfmap_pkg::DFMAP_H_PAR;
      end else if (reg_num == dfmap_pkg::REG_CMD_WORD) begin
        d.region = dfmap_pkg::DFMAP_H_CMD;
      end else if (reg_num == dfmap_pkg::REG_BUS_REF) begin
        d.region = dfmap_pkg::DFMAP_H_REF;
      end else if (reg_num == dfmap_pkg::REG_STATUS_WORD) begin
        d.region = dfmap_pkg::DFMAP_H_STW;
      end else if (reg_num == dfmap_pkg::REG_ACTUAL_VAL) begin
        d.region = dfmap_pkg::DFMAP_H_ACT;
      end
    end
  end

endmodule : dfmap_decode

// File: dfmap_pkg.sv
// Constants and types for the fieldbus data map of a motor drive.
// Assumes the follower logic hands over one decoded data address at a time.
package dfmap_pkg;

  // ---------------------------------------------------------------
  // Coil map (zero-based addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] COIL_CMD_BASE   = 16'h0000;
  localparam logic [15:0] COIL_REF_BASE   = 16'h0010;
  localparam logic [15:0] COIL_STAT_BASE  = 16'h0020;
  localparam logic [15:0] COIL_ACT_BASE   = 16'h0030;
  localparam logic [15:0] COIL_STORE_ADDR = 16'h0040;

  // ---------------------------------------------------------------
  // Holding register numbers (one-based, as numbered)
  // ---------------------------------------------------------------
  localparam logic [16:0] REG_LAST_ERROR  = 17'h00007;
  localparam logic [16:0] REG_ARRAY_INDEX = 17'h00009;
  localparam logic [16:0] REG_PARAM_FIRST = 17'h0000A;
  localparam logic [16:0] REG_PARAM_LAST  = 17'h0C34F;
  localparam logic [16:0] REG_CMD_WORD    = 17'h0C350;
  localparam logic [16:0] REG_BUS_REF     = 17'h0C35A;
  localparam logic [16:0] REG_STATUS_WORD = 17'h0C418;
  localparam logic [16:0] REG_ACTUAL_VAL  = 17'h0C422;
  localparam logic [16:0] REG_PARAM_STEP  = 17'h0000A;

  // ---------------------------------------------------------------
  // Command word bit positions
  // ---------------------------------------------------------------
  localparam int CMD_PRESET_LSB = 0;
  localparam int CMD_DC_BRAKE_N = 2;
  localparam int CMD_COAST_N    = 3;
  localparam int CMD_QSTOP_N    = 4;
  localparam int CMD_START      = 6;
  localparam int CMD_SETUP_LSB  = 13;

  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int STW_CTRL_READY  = 0;
  localparam int STW_DRV_READY   = 1;
  localparam int STW_SAFETY      = 2;
  localparam int STW_ALARM       = 3;
  localparam int STW_WARNING     = 7;
  localparam int STW_AT_REF      = 8;
  localparam int STW_AUTO        = 9;
  localparam int STW_IN_RANGE    = 10;
  localparam int STW_RUNNING     = 11;
  localparam int STW_VOLT_WARN   = 13;
  localparam int STW_CUR_LIMIT   = 14;
  localparam int STW_THERM_WARN  = 15;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_RESET   = 16'h0000;
  localparam logic [15:0] REF_RESET   = 16'h0000;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic        STORE_RESET = 1'b0;

  // Decoded target of one access
  typedef enum logic [3:0] {
    DFMAP_NONE  = 4'h0,
    DFMAP_C_CMD = 4'h1,
    DFMAP_C_REF = 4'h2,
    DFMAP_C_STW = 4'h3,
    DFMAP_C_ACT = 4'h4,
    DFMAP_C_STO = 4'h5,
    DFMAP_H_ERR = 4'h6,
    DFMAP_H_IDX = 4'h7,
    DFMAP_H_PAR = 4'h8,
    DFMAP_H_CMD = 4'h9,
    DFMAP_H_REF = 4'hA,
    DFMAP_H_STW = 4'hB,
    DFMAP_H_ACT = 4'hC
  } dfmap_region_t;

  typedef enum logic [0:0] {
    DFMAP_IDLE = 1'b0,
    DFMAP_PWAIT = 1'b1
  } dfmap_state_t;

endpackage : dfmap_pkg

// File: dfmap_pstore.sv
// Parameter store model behind the data map.
// Assumes one held request at a time.
module dfmap_pstore #(
  parameter logic [12:0] BAD_NUM = 13'h1387
) (
  // Clock and pacing
  input  logic        clk_sys,
  input  logic [3:0]  wait_len,
  // Request from the data map
  input  logic        par_valid,
  input  logic        par_write,
  input  logic [12:0] par_num,
  input  logic [3:0]  par_word,
  input  logic [15:0] par_index,
  input  logic [15:0] par_wdata,
  // Answer
  output logic        par_ack,
  output logic        par_err,
  output logic [15:0] par_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  int          cnt;
  int          key;

  // Answer after wait_len cycles
  initial begin
    par_ack   = 1'h0;
    par_err   = 1'h0;
    par_rdata = 16'h5AA5;
    cnt       = 0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (par_ack) begin
        par_ack   = 1'h0;
        par_rdata = ~par_rdata;
      end else if (par_valid && cnt < wait_len) begin
        cnt++;
      end else if (par_valid) begin
        cnt     = 0;
        key     = {par_num, par_word};
        par_ack = 1'h1;
        par_err = (par_num == BAD_NUM);
        if (par_write) mem[key] = par_wdata;
        par_rdata = mem.exists(key) ? mem[key] : {par_word, par_num[11:0]} ^ par_index;
      end
    end
  end
endmodule : dfmap_pstore

// File: dfmap_top.sv
// Data map of the drive's fieldbus follower: coils and holding registers.
// Assumes the follower logic on clk_sys hands over one single-object
// access at a time; framing and checksums are handled elsewhere.
module dfmap_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,

  // Query from the follower logic
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_coil,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,

  // Answer to the follower logic
  output logic             rsp_valid,
  output logic             rsp_exc,
  output logic [15:0]      rsp_data,

  // Drive state feeding the status word
  input  wire logic        drv_ctrl_ready,
  input  wire logic        drv_ready,
  input  wire logic        drv_safety_closed,
  input  wire logic        drv_alarm,
  input  wire logic        drv_warning,
  input  wire logic        drv_at_ref,
  input  wire logic        drv_auto_mode,
  input  wire logic        drv_in_range,
  input  wire logic        drv_running,
  input  wire logic        drv_volt_warn,
  input  wire logic        drv_cur_limit,
  input  wire logic        drv_therm_warn,

  // Drive values
  input  wire logic        drv_closed_loop,
  input  wire logic [15:0] drv_out_freq,
  input  wire logic [15:0] drv_feedback,
  input  wire logic [15:0] drv_last_error,

  // Commands to the drive
  output logic [15:0]      process_command_word,
  output logic [15:0]      process_bus_reference,
  output logic             par_store_nv,
  output logic [1:0]       preset_sel,
  output logic [1:0]       setup_sel,
  output logic             dc_brake_req,
  output logic             coast_req,
  output logic             quick_stop_req,
  output logic             start_req,

  // Parameter store access
  output logic             par_valid,
  output logic             par_write,
  output logic [12:0]      par_num,
  output logic [3:0]       par_word,
  output logic [15:0]      par_index,
  output logic [15:0]      par_wdata,
  input  wire logic        par_ack,
  input  wire logic        par_err,
  input  wire logic [15:0] par_rdata
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dfmap_pkg::dfmap_state_t state;
    logic                    ready;
    logic [15:0]             cmd;
    logic [15:0]             ref_val;
    logic                    store_nv;
    logic [15:0]             index;
    logic                    rsp_valid;
    logic                    rsp_exc;
    logic [15:0]             rsp_data;
    logic                    par_valid;
    logic                    par_write;
    logic [12:0]             par_num;
    logic [3:0]              par_word;
    logic [15:0]             par_wdata;
    logic [1:0]              preset;
    logic [1:0]              setup;
    logic                    dc_brake;
    logic                    coast;
    logic                    qstop;
    logic                    start;
  } dfmap_regs_t;

  dfmap_regs_t state_reg;
  dfmap_regs_t state_next;

  // ---------------------------------------------------------------
  // Address decoder
  // ---------------------------------------------------------------
  dfmap_dec_if dec_bus ();

  assign dec_bus.is_coil = req_coil;
  assign dec_bus.addr    = req_addr;

  dfmap_decode u_decode (
    .d (dec_bus.dec)
  );

  // ---------------------------------------------------------------
  // Live read values
  // ---------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] actual_val;

  // Unused status positions stay zero
  always_comb begin
    status_word = 16'h0000;
    status_word[dfmap_pkg::STW_CTRL_READY] = drv_ctrl_ready;
    status_word[dfmap_pkg::STW_DRV_READY]  = drv_ready;
    status_word[dfmap_pkg::STW_SAFETY]     = drv_safety_closed;
    status_word[dfmap_pkg::STW_ALARM]      = drv_alarm;
    status_word[dfmap_pkg::STW_WARNING]    = drv_warning;
    status_word[dfmap_pkg::STW_AT_REF]     = drv_at_ref;
    status_word[dfmap_pkg::STW_AUTO]       = drv_auto_mode;
    status_word[dfmap_pkg::STW_IN_RANGE]   = drv_in_range;
    status_word[dfmap_pkg::STW_RUNNING]    = drv_running;
    status_word[dfmap_pkg::STW_VOLT_WARN]  = drv_volt_warn;
    status_word[dfmap_pkg::STW_CUR_LIMIT]  = drv_cur_limit;
    status_word[dfmap_pkg::STW_THERM_WARN] = drv_therm_warn;
  end

  // Loop mode picks what the actual value shows
  assign actual_val = drv_closed_loop ? drv_feedback : drv_out_freq;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [3:0] bsel;

  assign bsel = dec_bus.bit_sel;

  always_comb begin
    state_next           = state_reg;
    state_next.rsp_valid = 1'b0;
    unique case (state_reg.state)
      dfmap_pkg::DFMAP_IDLE: begin
        if (req_valid) begin
          // Most accesses answer in the following cycle
          state_next.rsp_valid = 1'b1;
          state_next.rsp_exc   = 1'b0;
          state_next.rsp_data  = 16'h0000;
          unique case (dec_bus.region)
            dfmap_pkg::DFMAP_C_CMD: begin
              if (req_write) begin
                state_next.cmd[bsel] = req_wdata[0];
              end else begin
                state_next.rsp_data = {15'h0000, state_reg.cmd[bsel]};
              end
            end
            dfmap_pkg::DFMAP_C_REF: begin
              if (req_write) begin
                state_next.ref_val[bsel] = req_wdata[0];
              end else begin
                state_next.rsp_data = {15'h0000, state_reg.ref_val[bsel]};
              end
            end
            dfmap_pkg::DFMAP_C_STW: begin
              // Status bits belong to the drive, not the master
              state_next.rsp_exc  = req_write;
              state_next.rsp_data = req_write ? 16'h0000
                                    : {15'h0000, status_word[bsel]};
            end
            dfmap_pkg::DFMAP_C_ACT: begin
              state_next.rsp_exc  = req_write;
              state_next.rsp_data = req_write ? 16'h0000
                                    : {15'h0000, actual_val[bsel]};
            end
            dfmap_pkg::DFMAP_C_STO: begin
              if (req_write) begin
                state_next.store_nv = req_wdata[0];
              end else begin
                state_next.rsp_data = {15'h0000, state_reg.store_nv};
              end
            end
            dfmap_pkg::DFMAP_H_ERR: begin
              state_next.rsp_exc  = req_write;
              state_next.rsp_data = req_write ? 16'h0000
                                    : drv_last_error;
            end
            dfmap_pkg::DFMAP_H_IDX: begin
              if (req_write) begin
                state_next.index = req_wdata;
              end else begin
                state_next.rsp_data = state_reg.index;
              end
            end
            dfmap_pkg::DFMAP_H_PAR: begin
              // Hand off to the parameter store and wait
              state_next.rsp_valid = 1'b0;
              state_next.ready     = 1'b0;
              state_next.state     = dfmap_pkg::DFMAP_PWAIT;
              state_next.par_valid = 1'b1;
              state_next.par_write = req_write;
              state_next.par_num   = dec_bus.par_num;
              state_next.par_word  = dec_bus.par_word;
              state_next.par_wdata = req_wdata;
            end
            dfmap_pkg::DFMAP_H_CMD: begin
              if (req_write) begin
                state_next.cmd = req_wdata;
              end else begin
                state_next.rsp_data = state_reg.cmd;
              end
            end
            dfmap_pkg::DFMAP_H_REF: begin
              if (req_write) begin
                state_next.ref_val = req_wdata;
              end else begin
                state_next.rsp_data = state_reg.ref_val;
              end
            end
            dfmap_pkg::DFMAP_H_STW: begin
              state_next.rsp_exc  = req_write;
              state_next.rsp_data = req_write ? 16'h0000
                                    : status_word;
            end
            dfmap_pkg::DFMAP_H_ACT: begin
              state_next.rsp_exc  = req_write;
              state_next.rsp_data = req_write ? 16'h0000
                                    : actual_val;
            end
            default: begin
              // Reserved object: nothing stored, nothing returned
              state_next.rsp_exc = 1'b1;
            end
          endcase
        end
      end
      dfmap_pkg::DFMAP_PWAIT: begin
        // Held until the store acknowledges; no timeout here
        if (par_ack) begin
          state_next.par_valid = 1'b0;
          state_next.rsp_valid = 1'b1;
          state_next.rsp_exc   = par_err;
          state_next.rsp_data  = (par_err || state_reg.par_write) ? 16'h0000
                                 : par_rdata;
          state_next.ready     = 1'b1;
          state_next.state     = dfmap_pkg::DFMAP_IDLE;
        end
      end
    endcase

    // Command fields follow the stored command word
    state_next.preset = state_next.cmd[dfmap_pkg::CMD_PRESET_LSB +: 2];
    state_next.setup  = state_next.cmd[dfmap_pkg::CMD_SETUP_LSB +: 2];
    state_next.dc_brake = ~state_next.cmd[dfmap_pkg::CMD_DC_BRAKE_N];
    state_next.coast    = ~state_next.cmd[dfmap_pkg::CMD_COAST_N];
    state_next.qstop    = ~state_next.cmd[dfmap_pkg::CMD_QSTOP_N];
    state_next.start    = state_next.cmd[dfmap_pkg::CMD_START];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= '0;
      state_reg.state     <= dfmap_pkg::DFMAP_IDLE;
      state_reg.ready     <= 1'b1;
      state_reg.cmd       <= dfmap_pkg::CMD_RESET;
      state_reg.ref_val   <= dfmap_pkg::REF_RESET;
      state_reg.store_nv  <= dfmap_pkg::STORE_RESET;
      state_reg.index     <= dfmap_pkg::INDEX_RESET;
      // All-zero command means every stop request is active
      state_reg.dc_brake  <= 1'b1;
      state_reg.coast     <= 1'b1;
      state_reg.qstop     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign req_ready             = state_reg.ready;
  assign rsp_valid             = state_reg.rsp_valid;
  assign rsp_exc               = state_reg.rsp_exc;
  assign rsp_data              = state_reg.rsp_data;
  assign process_command_word  = state_reg.cmd;
  assign process_bus_reference = state_reg.ref_val;
  assign par_store_nv          = state_reg.store_nv;
  assign preset_sel            = state_reg.preset;
  assign setup_sel             = state_reg.setup;
  assign dc_brake_req          = state_reg.dc_brake;
  assign coast_req             = state_reg.coast;
  assign quick_stop_req        = state_reg.qstop;
  assign start_req             = state_reg.start;
  assign par_valid             = state_reg.par_valid;
  assign par_write             = state_reg.par_write;
  assign par_num               = state_reg.par_num;
  assign par_word              = state_reg.par_word;
  assign par_index             = state_reg.index;
  assign par_wdata             = state_reg.par_wdata;

endmodule : dfmap_top

// File: drive_fieldbus_data_map_bench.sv
// Bench: access calls with expected answers.
// Assumes the store model answers each request.
module drive_fieldbus_data_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic C = 1'h1, H = 1'h0, W = 1'h1, R = 1'h0;
  logic        clk_sys, rst_n, req_valid, req_ready, req_coil, req_write;
  logic        rsp_valid, rsp_exc, par_store_nv, par_valid, par_write, par_ack, par_err;
  logic        dc_brake_req, coast_req, quick_stop_req, start_req, drv_closed_loop;
  logic [1:0]  preset_sel, setup_sel;
  logic [3:0]  par_word, wait_len;
  logic [11:0] drv_st;
  logic [12:0] par_num;
  logic [15:0] req_addr, req_wdata, rsp_data, process_command_word, process_bus_reference;
  logic [15:0] par_index, par_wdata, par_rdata, drv_out_freq, drv_feedback, drv_last_error, exp;
  logic [15:0] cw [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0006, 16'h000D, 16'h000F};
  logic [16:0] rv [7] = '{17'h10041, 17'h1FFFF, 17'h00000, 17'h00005, 17'h00007,
                          17'h0C350, 17'h0C418};
  logic [11:0] sp [2] = '{12'hA5C, 12'h5A3};
  int          err_count, compares;

  dfmap_top u_dut (.clk_sys, .rst_n, .req_valid, .req_ready, .req_coil, .req_write,
    .req_addr, .req_wdata, .rsp_valid, .rsp_exc, .rsp_data, .drv_ctrl_ready(drv_st[0]),
    .drv_ready(drv_st[1]), .drv_safety_closed(drv_st[2]), .drv_alarm(drv_st[3]),
    .drv_warning(drv_st[4]), .drv_at_ref(drv_st[5]), .drv_auto_mode(drv_st[6]),
    .drv_in_range(drv_st[7]), .drv_running(drv_st[8]), .drv_volt_warn(drv_st[9]),
    .drv_cur_limit(drv_st[10]), .drv_therm_warn(drv_st[11]), .drv_closed_loop,
    .drv_out_freq, .drv_feedback, .drv_last_error, .process_command_word,
    .process_bus_reference, .par_store_nv, .preset_sel, .setup_sel, .dc_brake_req,
    .coast_req, .quick_stop_req, .start_req, .par_valid, .par_write, .par_num, .par_word,
    .par_index, .par_wdata, .par_ack, .par_err, .par_rdata);
  dfmap_pstore u_store (.clk_sys, .wait_len, .par_valid, .par_write, .par_num, .par_word,
    .par_index, .par_wdata, .par_ack, .par_err, .par_rdata);

  // 100 MHz clock
  initial clk_sys = 1'h0;
  always #5 clk_sys = ~clk_sys;

  task automatic cmp(input string what, input logic [15:0] want, got);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, want, got);
    end
  endtask : cmp

  // One access; valid stays up after a prompt answer
  task automatic acc(input logic coil, wr, input logic [15:0] addr, wd, want,
                     input logic x);
    int   n;
    logic rdy;
    {req_coil, req_write, req_addr, req_wdata, req_valid} = {coil, wr, addr, wd, 1'h1};
    n = 0;
    do begin
      rdy = req_ready;
      @(posedge clk_sys);
      #1;
      n++;
    end while (rdy !== 1'h1 && n < 60);
    if (rsp_valid !== 1'h1) req_valid = 1'h0;
    while (rsp_valid !== 1'h1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cmp("rsp_valid", 16'h0001, rsp_valid);
    cmp("rsp_exc", x, rsp_exc);
    cmp("rsp_data", want, rsp_data);
  endtask : acc

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    {rst_n, req_valid, req_coil, req_write, drv_closed_loop} = 5'h00;
    {req_addr, req_wdata, drv_out_freq, drv_feedback} = 64'h0000_0000_1234_BEEF;
    {drv_last_error, drv_st, wait_len, err_count, compares} = {16'h0BAD, 16'h0000, 64'h0};
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'h1;
    cmp("cmd", 16'h0000, process_command_word);
    cmp("stop", 16'h000E, {dc_brake_req, coast_req, quick_stop_req, start_req});
    cmp("store", 16'h0000, par_store_nv);
    $display("test reset done");
    foreach (cw[i]) acc(C, W, cw[i], 16'h0001, 16'h0000, 1'h0);
    cmp("cmd", 16'hA047, process_command_word);
    cmp("sel", 16'h000D, {preset_sel, setup_sel});
    cmp("stop", 16'h0007, {dc_brake_req, coast_req, quick_stop_req, start_req});
    acc(C, R, 16'h0006, 16'h0000, 16'h0001, 1'h0);
    acc(C, R, 16'h0003, 16'h0000, 16'h0000, 1'h0);
    acc(H, R, 16'hC34F, 16'h0000, 16'hA047, 1'h0);
    acc(H, W, 16'hC359, 16'h8001, 16'h0000, 1'h0);
    cmp("ref", 16'h8001, process_bus_reference);
    acc(C, R, 16'h0010, 16'h0000, 16'h0001, 1'h0);
    acc(C, R, 16'h001F, 16'h0000, 16'h0001, 1'h0);
    acc(C, R, 16'h0011, 16'h0000, 16'h0000, 1'h0);
    $display("test command done");
    foreach (sp[i]) begin
      drv_st = sp[i];
      exp = {drv_st[11:9], 1'h0, drv_st[8:4], 3'h0, drv_st[3:0]};
      acc(H, R, 16'hC417, 16'h0000, exp, 1'h0);
      acc(C, R, 16'h0023, 16'h0000, {15'h0000, drv_st[3]}, 1'h0);
      acc(C, R, 16'h0024, 16'h0000, 16'h0000, 1'h0);
    end
    for (int cl = 0; cl < 2; cl++) begin
      drv_closed_loop = cl[0];
      exp = cl[0] ? 16'hBEEF : 16'h1234;
      acc(H, R, 16'hC421, 16'h0000, exp, 1'h0);
      acc(C, R, 16'h0030, 16'h0000, {15'h0000, exp[0]}, 1'h0);
      acc(C, R, 16'h003F, 16'h0000, {15'h0000, exp[15]}, 1'h0);
    end
    $display("test status done");
    acc(C, W, 16'h0040, 16'h0001, 16'h0000, 1'h0);
    cmp("store", 16'h0001, par_store_nv);
    acc(C, R, 16'h0040, 16'h0000, 16'h0001, 1'h0);
    foreach (rv[i]) acc(rv[i][16], R, rv[i][15:0], 16'h0000, 16'h0000, 1'h1);
    acc(C, W, 16'h0020, 16'h0001, 16'h0000, 1'h1);
    acc(H, W, 16'hC417, 16'h0001, 16'h0000, 1'h1);
    acc(H, W, 16'h0006, 16'h0001, 16'h0000, 1'h1);
    acc(H, R, 16'h0006, 16'h0000, 16'h0BAD, 1'h0);
    $display("test reserved done");
    acc(H, W, 16'h0C2F, 16'h1352, 16'h0000, 1'h0);
    acc(H, W, 16'h0008, 16'h0002, 16'h0000, 1'h0);
    acc(H, R, 16'h0008, 16'h0000, 16'h0002, 1'h0);
    wait_len = 4'h5;
    acc(H, R, 16'h0C2F, 16'h0000, 16'h1352, 1'h0);
    acc(H, R, 16'h0D52, 16'h0000, 16'h1157, 1'h0);
    acc(H, R, 16'h0009, 16'h0000, 16'h0003, 1'h0);
    acc(H, R, 16'hC34E, 16'h0000, 16'h0000, 1'h1);
    $display("test parameters done");
    report_and_stop();
  end

  // Watchdog, far past the test length
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
endmodule : drive_fieldbus_data_map_bench
